//--- src/sbsr_pkg.sv
// Package for the status byte and service request block.
// Assumes one clock; all users write sbsr_pkg::name.
package sbsr_pkg;

  localparam int          BYTE_W         = 8;

  // Primary event status byte, bit positions
  localparam int          PRI_PARAM_ALT  = 0;
  localparam int          PRI_EXT_CHANGE = 2;
  localparam int          PRI_END_SWEEP  = 4;
  localparam int          PRI_SYNTAX_ERR = 5;
  localparam int          PRI_REQ_FLAG   = 6;

  // Extended condition status byte, bit positions
  localparam int          EXT_SELF_TEST  = 0;
  localparam int          EXT_POWER_FAIL = 5;
  localparam int          EXT_RF_UNLEV   = 6;
  localparam int          EXT_AIRFLOW    = 7;

  // Bits that exist as sticky condition flags
  localparam logic [7:0]  PRI_USED       = 8'h35;
  localparam logic [7:0]  EXT_USED       = 8'he1;
  // Primary bits that may raise a request
  localparam logic [7:0]  SRQ_SOURCES    = 8'h35;

  localparam logic [7:0]  STATUS_RESET   = 8'h00;
  localparam logic [7:0]  MASK_RESET     = 8'h00;
  // Altered parameter, syntax error and the request flag
  localparam logic [7:0]  MASK_EXAMPLE   = 8'h61;

endpackage : sbsr_pkg

//--- src/sbsr_flag_if.sv
// Carrier between the block and its sticky flag banks.
// Assumes the owner of the bank modport runs on the block clock.
`timescale 1ns/100ps
`default_nettype none

interface sbsr_flag_if #(
  parameter int WIDTH = 8
);
  logic [WIDTH-1:0] set;
  logic             clr;
  logic [WIDTH-1:0] q;

  modport bank (input set, input clr, output q);
  modport user (output set, output clr, input q);
endinterface : sbsr_flag_if

`default_nettype wire

//--- src/sbsr_sticky_bank.sv
// Bank of sticky condition flags, one status byte wide.
// Assumes set and clear are synchronous to clk.
`timescale 1ns/100ps
`default_nettype none

module sbsr_sticky_bank #(
  parameter int               WIDTH = 8,
  parameter logic [WIDTH-1:0] USED  = '1
) (
  input wire logic clk,
  input wire logic rst_n,
  sbsr_flag_if.bank flags
);

  if (WIDTH != sbsr_pkg::BYTE_W) begin : g_bad_width
    $error("sbsr_sticky_bank: status bytes are exactly eight bits");
  end

  logic [WIDTH-1:0] q_reg;
  logic [WIDTH-1:0] q_next;

  // Set beats clear so an event landing on the clear is kept
  assign q_next  = ((q_reg & ~{WIDTH{flags.clr}}) | flags.set) & USED;
  assign flags.q = q_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

endmodule : sbsr_sticky_bank

`default_nettype wire

//--- src/sbsr_status_srq.sv
// Status bytes, request mask and service request of the instrument.
// Assumes event inputs, commands and clears are synchronous to REF_CLK.
//
// Behaviour
// - Two separate eight-bit status bytes, each bit one condition.
// - Bits numbered 0 to 7, bit 0 least significant.
// - Request raised only by active conditions enabled in the mask.
// - Mask value 97 enables altered-parameter, syntax-error and request flag.
// - Primary bit 0 flags a numeric parameter forced to default.
// - Primary bit 5 flags a command syntax error.
// - Primary bit 6 request, 4 end sweep, 2 extended change.
// - Extended bits: 7 airflow, 6 unleveled, 5 power, 0 self test.
// - Device clear empties status, keeping an event on the clear cycle; a new request may then rise.
// - Unleveled RF and power failure each report separately.
`timescale 1ns/100ps
`default_nettype none

module sbsr_status_srq (
  input  wire logic       REF_CLK,
  input  wire logic       RST_N,
  input  wire logic       PARAM_ALTERED,
  input  wire logic       SYNTAX_ERROR,
  input  wire logic       END_OF_SWEEP,
  input  wire logic       AIRFLOW_FAIL,
  input  wire logic       RF_UNLEVELED,
  input  wire logic       POWER_FAIL,
  input  wire logic       SELF_TEST_FAIL,
  input  wire logic       DEV_CLEAR,
  input  wire logic       PRESET,
  input  wire logic       MASK_WR,
  input  wire logic [7:0] MASK_DATA,
  input  wire logic       STATUS_RD,
  output logic      [7:0] STATUS_PRIMARY,
  output logic      [7:0] STATUS_EXTENDED,
  output logic            STATUS_VALID,
  output logic      [7:0] MASK_Q,
  output logic            SERVICE_REQUESTED_FLAG,
  output logic            SRQ_O,
  output logic            SRQ_OE
);

  ////////////////////////////////////////////////////////////////////////////
  // Sticky condition banks

  sbsr_flag_if #(.WIDTH(sbsr_pkg::BYTE_W)) pri_if ();
  sbsr_flag_if #(.WIDTH(sbsr_pkg::BYTE_W)) ext_if ();

  logic [7:0] pri_q;
  logic [7:0] ext_q;
  logic [7:0] ext_set;
  logic [7:0] pri_set;
  logic       ext_new;
  logic       clear_all;
  logic       pwr_on_reg;

  assign clear_all = DEV_CLEAR | PRESET;

  // Power-up is reported once, like a power failure
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pwr_on_reg <= 1'b1;
    end else begin
      pwr_on_reg <= 1'b0;
    end
  end

  always_comb begin
    ext_set = 8'h00;
    ext_set[sbsr_pkg::EXT_AIRFLOW]    = AIRFLOW_FAIL;
    ext_set[sbsr_pkg::EXT_RF_UNLEV]   = RF_UNLEVELED;
    ext_set[sbsr_pkg::EXT_POWER_FAIL] = POWER_FAIL | pwr_on_reg;
    ext_set[sbsr_pkg::EXT_SELF_TEST]  = SELF_TEST_FAIL;
  end

  // Only a condition not already held counts as a change
  assign ext_new = |(ext_set & ~ext_q & sbsr_pkg::EXT_USED);

  always_comb begin
    pri_set = 8'h00;
    pri_set[sbsr_pkg::PRI_PARAM_ALT]  = PARAM_ALTERED;
    pri_set[sbsr_pkg::PRI_EXT_CHANGE] = ext_new;
    pri_set[sbsr_pkg::PRI_END_SWEEP]  = END_OF_SWEEP;
    pri_set[sbsr_pkg::PRI_SYNTAX_ERR] = SYNTAX_ERROR;
  end

  assign pri_if.set = pri_set;
  assign pri_if.clr = clear_all;
  assign ext_if.set = ext_set;
  assign ext_if.clr = clear_all;
  assign pri_q      = pri_if.q;
  assign ext_q      = ext_if.q;

  sbsr_sticky_bank #(
    .WIDTH (sbsr_pkg::BYTE_W),
    .USED  (sbsr_pkg::PRI_USED)
  ) u_pri_bank (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .flags (pri_if.bank)
  );

  sbsr_sticky_bank #(
    .WIDTH (sbsr_pkg::BYTE_W),
    .USED  (sbsr_pkg::EXT_USED)
  ) u_ext_bank (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .flags (ext_if.bank)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Request mask and service request

  logic [7:0] mask_reg;
  logic [7:0] mask_next;
  logic       req_flag_reg;
  logic       req_flag_next;

  // Preset restores the mask; a device clear leaves it armed
  assign mask_next = PRESET  ? sbsr_pkg::MASK_RESET :
                     MASK_WR ? MASK_DATA : mask_reg;

  // Mask bit 6 has no source; primary bit 6 only mirrors the request flag
  assign req_flag_next = |(pri_q & mask_reg & sbsr_pkg::SRQ_SOURCES);

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mask_reg     <= sbsr_pkg::MASK_RESET;
      req_flag_reg <= 1'b0;
    end else begin
      mask_reg     <= mask_next;
      req_flag_reg <= req_flag_next;
    end
  end

  assign MASK_Q                 = mask_reg;
  assign SERVICE_REQUESTED_FLAG = req_flag_reg;
  // Open-drain request line: pulled low while enabled
  assign SRQ_O                  = 1'b0;
  assign SRQ_OE                 = req_flag_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Status read by the controller

  logic [7:0] pri_view;
  logic [7:0] rd_pri_reg;
  logic [7:0] rd_ext_reg;
  logic       rd_valid_reg;

  always_comb begin
    pri_view = pri_q;
    pri_view[sbsr_pkg::PRI_REQ_FLAG] = req_flag_reg;
  end

  // Snapshot keeps both bytes coherent for one poll
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_pri_reg   <= sbsr_pkg::STATUS_RESET;
      rd_ext_reg   <= sbsr_pkg::STATUS_RESET;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= STATUS_RD;
      if (STATUS_RD) begin
        rd_pri_reg <= pri_view;
        rd_ext_reg <= ext_q;
      end
    end
  end

  assign STATUS_PRIMARY  = rd_pri_reg;
  assign STATUS_EXTENDED = rd_ext_reg;
  assign STATUS_VALID    = rd_valid_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [7:0] enabled_q;
  assign enabled_q = pri_q & mask_reg & sbsr_pkg::SRQ_SOURCES;

  property p_srq_enabled;
    @(posedge REF_CLK) disable iff (!RST_N)
      (enabled_q != 8'h00) |=> (SRQ_OE && SERVICE_REQUESTED_FLAG);
  endproperty
  a_srq_enabled: assert property (p_srq_enabled)
    else $error("request not raised for enabled condition");

  property p_no_srq_masked;
    @(posedge REF_CLK) disable iff (!RST_N)
      (enabled_q == 8'h00) |=> !SRQ_OE;
  endproperty
  a_no_srq_masked: assert property (p_no_srq_masked)
    else $error("request raised with no enabled condition");

  property p_param_alt;
    @(posedge REF_CLK) disable iff (!RST_N)
      PARAM_ALTERED |=> pri_q[0];
  endproperty
  a_param_alt: assert property (p_param_alt)
    else $error("altered parameter not flagged in bit 0");

  property p_syntax;
    @(posedge REF_CLK) disable iff (!RST_N)
      SYNTAX_ERROR |=> pri_q[5];
  endproperty
  a_syntax: assert property (p_syntax)
    else $error("syntax error not flagged in bit 5");

  property p_ext_change;
    @(posedge REF_CLK) disable iff (!RST_N)
      (RF_UNLEVELED && !ext_q[6]) |=> (ext_q[6] && pri_q[2]);
  endproperty
  a_ext_change: assert property (p_ext_change)
    else $error("unleveled RF did not mark extended change");

  property p_sticky;
    @(posedge REF_CLK) disable iff (!RST_N)
      (pri_q[0] && !clear_all) [*2] |=> pri_q[0];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("condition bit dropped without a clear");

  property p_clear;
    @(posedge REF_CLK) disable iff (!RST_N)
      (DEV_CLEAR && ext_set == 8'h00 && pri_set == 8'h00) |=>
        (pri_q == 8'h00 && ext_q == 8'h00) ##1 !SRQ_OE;
  endproperty
  a_clear: assert property (p_clear)
    else $error("device clear left status or request set");

  property p_unused_zero;
    @(posedge REF_CLK) disable iff (!RST_N)
      (pri_q[7] | pri_q[3] | pri_q[1] | (|ext_q[4:1])) == 1'b0;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused status bit set");

  property p_mask_wr;
    @(posedge REF_CLK) disable iff (!RST_N)
      (MASK_WR && !PRESET) |=> (MASK_Q == $past(MASK_DATA));
  endproperty
  a_mask_wr: assert property (p_mask_wr)
    else $error("mask command not stored");

  property p_status_rd;
    @(posedge REF_CLK) disable iff (!RST_N)
      STATUS_RD |=> (STATUS_VALID && STATUS_PRIMARY[6] == $past(req_flag_reg)
                     && STATUS_EXTENDED == $past(ext_q));
  endproperty
  a_status_rd: assert property (p_status_rd)
    else $error("status read returned wrong bytes");

  property p_power_fail;
    @(posedge REF_CLK) disable iff (!RST_N)
      POWER_FAIL |=> ext_q[5];
  endproperty
  a_power_fail: assert property (p_power_fail)
    else $error("power failure not flagged in extended bit 5");

  c_mask_97: cover property (@(posedge REF_CLK) disable iff (!RST_N)
      (MASK_Q == sbsr_pkg::MASK_EXAMPLE) && PARAM_ALTERED ##2 SRQ_OE);
  c_clear_rearm: cover property (@(posedge REF_CLK) disable iff (!RST_N)
      SRQ_OE ##1 DEV_CLEAR ##2 !SRQ_OE ##[1:20] SRQ_OE);
  c_poll_during_srq: cover property (@(posedge REF_CLK) disable iff (!RST_N)
      SRQ_OE && STATUS_RD ##1 STATUS_VALID);
  c_set_on_clear: cover property (@(posedge REF_CLK) disable iff (!RST_N)
      DEV_CLEAR && SYNTAX_ERROR ##1 pri_q[5]);

endmodule : sbsr_status_srq

`default_nettype wire

//--- dv/sbsr_ctrl_model.sv
// Bus controller model: mask writes, status polls and device clears.
// Assumes the block samples every strobe on the rising clock edge.
`timescale 1ns/100ps
`default_nettype none

module sbsr_ctrl_model (
  input  wire logic       clk,
  output logic            mask_wr,
  output logic      [7:0] mask_data,
  output logic            status_rd,
  output logic            dev_clear
);
  initial begin
    mask_wr   = 1'b0;
    mask_data = 8'h00;
    status_rd = 1'b0;
    dev_clear = 1'b0;
  end

  // Mask byte is the sum of the chosen bit weights
  task automatic write_mask(input logic [7:0] v);
    @(posedge clk);
    #2;
    mask_wr   = 1'b1;
    mask_data = v;
    @(posedge clk);
    #2;
    mask_wr   = 1'b0;
    // Released byte must not look like the last value
    mask_data = ~v;
  endtask : write_mask

  task automatic poll();
    @(posedge clk);
    #2;
    status_rd = 1'b1;
    @(posedge clk);
    #2;
    status_rd = 1'b0;
  endtask : poll

  task automatic clear();
    @(posedge clk);
    #2;
    dev_clear = 1'b1;
    @(posedge clk);
    #2;
    dev_clear = 1'b0;
  endtask : clear
endmodule : sbsr_ctrl_model

`default_nettype wire

//--- dv/test_sbsr_status_srq.sv
// Self-checking bench for the status byte and service request block.
// Assumes the controller model drives mask, poll and clear strobes.
`timescale 1ns/100ps
`default_nettype none

module test_sbsr_status_srq;
  logic        REF_CLK      = 1'b0;
  logic        RST_N        = 1'b0;
  logic [6:0]  ev           = 7'h00;
  logic        preset       = 1'b0;
  logic        mask_wr;
  logic        status_rd;
  logic        dev_clear;
  logic [7:0]  mask_data;
  logic [7:0]  pri_q;
  logic [7:0]  ext_q;
  logic [7:0]  mask_q;
  logic        valid;
  logic        flag;
  logic        srq_oe;
  logic [15:0] exp_q[$];
  logic [15:0] note;
  logic [7:0]  msk;
  logic        srq;
  logic        srq_o;
  int          err_count    = 0;
  int          total_checks = 0;
  // Per event input: expected primary and extended bytes
  localparam logic [7:0] PRI_TAB [7] = '{8'h01, 8'h20, 8'h10, 8'h04, 8'h04, 8'h04, 8'h04};
  localparam logic [7:0] EXT_TAB [7] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h40, 8'h20, 8'h01};

  always #12.5 REF_CLK = ~REF_CLK;

  sbsr_ctrl_model u_ctrl (.clk(REF_CLK), .mask_wr(mask_wr), .mask_data(mask_data),
    .status_rd(status_rd), .dev_clear(dev_clear));

  sbsr_status_srq dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .PARAM_ALTERED(ev[0]),
    .SYNTAX_ERROR(ev[1]), .END_OF_SWEEP(ev[2]), .AIRFLOW_FAIL(ev[3]),
    .RF_UNLEVELED(ev[4]), .POWER_FAIL(ev[5]), .SELF_TEST_FAIL(ev[6]),
    .DEV_CLEAR(dev_clear), .PRESET(preset), .MASK_WR(mask_wr), .MASK_DATA(mask_data),
    .STATUS_RD(status_rd), .STATUS_PRIMARY(pri_q), .STATUS_EXTENDED(ext_q),
    .STATUS_VALID(valid), .MASK_Q(mask_q), .SERVICE_REQUESTED_FLAG(flag),
    .SRQ_O(srq_o), .SRQ_OE(srq_oe));

  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    total_checks++;
    if (got !== want) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk

  task automatic test_done();
    if (err_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  task automatic poll(input logic [7:0] p, input logic [7:0] e);
    exp_q.push_back({p, e});
    u_ctrl.poll();
    settle(2);
  endtask : poll

  task automatic chk_srq(input logic want);
    // Open-drain data stays low; only the enable carries the request
    chk({13'h0, srq_o, flag, srq_oe}, {13'h0, 1'b0, want, want});
  endtask : chk_srq

  task automatic settle(input int n);
    repeat (n) @(posedge REF_CLK);
    #2;
  endtask : settle

  // Poll results come back one cycle later; oldest note first
  always @(negedge REF_CLK) begin
    if (valid === 1'b1) begin
      note = exp_q.pop_front();
      chk({pri_q, ext_q}, note);
    end
  end

  initial begin
    #200000;
    err_count++;
    test_done();
  end

  initial begin
    void'($urandom(59981));
    settle(12);
    RST_N = 1'b1;
    settle(2);
    chk_srq(1'b0);
    poll(8'h04, 8'h20);
    u_ctrl.write_mask(8'h61);
    chk({8'h00, mask_q}, 16'h0061);
    for (int i = 0; i < 7; i++) begin
      for (int k = 0; k < 3; k++) begin
        msk = (k == 0) ? 8'h61 : 8'($urandom());
        u_ctrl.clear();
        u_ctrl.write_mask(msk);
        srq = |(PRI_TAB[i] & msk & 8'h35);
        settle(1);
        ev[i] = 1'b1;
        settle(1);
        ev = 7'h00;
        settle(2);
        chk_srq(srq);
        poll(PRI_TAB[i] | {1'b0, srq, 6'h00}, EXT_TAB[i]);
        chk_srq(srq);
        u_ctrl.clear();
        settle(1);
        chk_srq(1'b0);
      end
    end
    poll(8'h00, 8'h00);
    settle(1);
    preset = 1'b1;
    settle(1);
    preset = 1'b0;
    settle(1);
    chk({8'h00, mask_q}, 16'h0000);
    settle(2);
    chk(16'(exp_q.size()), 16'h0000);
    test_done();
  end
endmodule : test_sbsr_status_srq

`default_nettype wire
